// >>> fdr_cfg.svh
// constants of the fault diagnostic reporter: offsets, fields, resets, timing
// assumes a 10 MHz pclk and an APB master with 32-bit data
// Notes on behaviour
// - status bit 15 is the common fault flag, set when any fault bit is set
// - serial output shows the common fault flag as soon as strobe goes low, with either word selected; the detail word's first bit then gives 0
// - fault bits latch; cleared only after a serial read with clear inhibit low, or by a supply reset
// - detail register: per-switch drain-source and bootstrap faults plus overspeed flag
// - non-critical diagnostics can each be suppressed by a mask bit
// - serial output can carry a divided copy of the system clock
// - report pin is open drain: pulls low only, high by external pull-up
// - select 0: pin low while any fault present or latched
// - select 1: pin carries speed tach, high while motor stationary
// - select 2: group pulses, pin high with no fault
// - select 3: group pulses on fault, speed tach when fault free
// - select 2: demand detector holds last value while pin is low
// - low times: undervoltage 2.5 s, temperature 2 s, short 1 s, lock 1.5 s
// - pulse modes: pin high 1 s between low periods, except system error
// - ranks lock 1 to system 5; only the highest group is reported
// - system error holds the pin low continuously in selects 0, 2 and 3
// - fault to group mapping; serial error, supply reset, warning are no fault
// - power-on-reset state or serial read with inhibit low clears latched state
// - supply reset or gate regulator undervoltage force all gate drives off
// - loss of synchronisation sets the sync lost bit, feeding motor lock
`ifndef FDR_CFG_SVH
`define FDR_CFG_SVH
`define FDR_OFS_CTRL    8'h00
`define FDR_OFS_MASK    8'h04
`define FDR_OFS_STATUS  8'h08
`define FDR_OFS_DETAIL  8'h0C
`define FDR_OFS_REPORT  8'h10
`define FDR_CTRL_RST    32'h0000_0000
`define FDR_MASK_RST    7'h00
`define FDR_CTRL_SEL_LO 0
`define FDR_CTRL_INH    2
`define FDR_CTRL_CKEN   3
`define FDR_CTRL_DIV_LO 8
`define FDR_MSK_TW      0
`define FDR_MSK_OT      1
`define FDR_MSK_BBUV    2
`define FDR_MSK_BSUV    3
`define FDR_MSK_DSOV    4
`define FDR_MSK_LOCK    5
`define FDR_MSK_OSPD    6
`define FDR_ST_FF       15
`define FDR_ST_SYS      14
`define FDR_ST_SER      13
`define FDR_ST_BBPOR    12
`define FDR_ST_BBUV     11
`define FDR_ST_LRUV     10
`define FDR_ST_GRUV     9
`define FDR_ST_BSUV     8
`define FDR_ST_TW       7
`define FDR_ST_OT       6
`define FDR_ST_DSOV     5
`define FDR_ST_LOCK     4
`define FDR_ST_OSPD     3
`define FDR_DT_DSOV_LO  0
`define FDR_DT_BSUV_LO  6
`define FDR_DT_OSPD     12
`define FDR_CLK_HZ      10000000
`define FDR_TICK_MS     100
`define FDR_T_UV_MS     2500
`define FDR_T_OT_MS     2000
`define FDR_T_SD_MS     1000
`define FDR_T_LK_MS     1500
`define FDR_T_HIGH_MS   1000
`define FDR_WORD_BITS   16
`endif

// >>> fdr_host_model.sv
// host model: report pin through a pull-up, serial word reader
// assumes pclk paces every change
`timescale 1ns/1ps
module fdr_host_model (
    input  wire logic pclk,     // clock
    input  wire logic pin_o,    // pin value
    input  wire logic pin_oe_n, // low while pulling
    input  wire logic sdo,      // serial out
    output logic      strobe_n = 1'h1, // strobe
    output logic      sclk = 1'h0,     // shift clock
    output logic      word_sel = 1'h0, // word choice
    output wire logic pin_lvl   // pin level
);
    // a released pin rises to the pull-up
    assign pin_lvl = pin_oe_n ? 1'h1 : pin_o;
    // bit shows 2 clocks after a rise, so each phase lasts 3
    task automatic read_word(input logic ws, output logic [15:0] w);
        word_sel <= ws;
        @(posedge pclk);
        strobe_n <= 1'h0;
        for (int i = 15; i >= 0; i--) begin
            repeat (3) @(posedge pclk);
            w[i] = sdo;
            sclk <= 1'h1;
            repeat (3) @(posedge pclk);
            sclk <= 1'h0;
        end
        @(posedge pclk);
        strobe_n <= 1'h1;
        repeat (4) @(posedge pclk);
    endtask
    task automatic wait_lvl(input logic v);
        for (int n = 0; n < 4000 && pin_lvl !== v; n++) @(posedge pclk);
    endtask
    // skip a pattern already under way
    task automatic pulse_times(output int lo, output int hi);
        lo = 0;
        hi = 0;
        wait_lvl(1'h0);
        wait_lvl(1'h1);
        wait_lvl(1'h0);
        for (; pin_lvl === 1'h0 && lo < 4000; lo++) @(posedge pclk);
        for (; pin_lvl === 1'h1 && hi < 4000; hi++) @(posedge pclk);
    endtask
endmodule

// >>> fdr_pkg.sv
// types of the fault diagnostic reporter
// assumes fdr_cfg.svh holds the numbers
package fdr_pkg;
    typedef enum logic [1:0] {
        FDR_IDLE = 2'b00,
        FDR_LOW  = 2'b01,
        FDR_HIGH = 2'b11
    } fdr_pulse_t;
    typedef enum logic [2:0] {
        FDR_G_NONE = 3'h0,
        FDR_G_LOCK = 3'h1,
        FDR_G_SD   = 3'h2,
        FDR_G_OT   = 3'h3,
        FDR_G_UV   = 3'h4,
        FDR_G_SYS  = 3'h5
    } fdr_group_t;
endpackage

// >>> fdr_top.sv
// fault diagnostic reporter: fault latches, serial status, report pin, gate off
// assumes all inputs synchronous to pclk and an APB master for the registers
`timescale 1ns/1ps
`include "fdr_cfg.svh"
module fdr_top import fdr_pkg::*; #(
    parameter int SWITCHES = 6,                   // bridge switches
    parameter int TICK_CYC = `FDR_CLK_HZ / 1000 * `FDR_TICK_MS, // cycles per tick
    parameter int DIV_W    = 4                    // clock divider field width
) (
    input  wire logic                pclk,           // system clock
    input  wire logic                presetn,        // async reset, active low
    input  wire logic                psel,           // apb select
    input  wire logic                penable,        // apb enable
    input  wire logic                pwrite,         // apb direction
    input  wire logic [7:0]          paddr,          // apb byte address
    input  wire logic [31:0]         pwdata,         // apb write data
    output logic      [31:0]         prdata,         // apb read data
    output logic                     pready,         // apb ready
    output logic                     pslverr,        // apb error
    input  wire logic                sys_err,        // system error
    input  wire logic                serial_err,     // serial error
    input  wire logic                bridge_supply_por, // bridge supply reset
    input  wire logic                bridge_supply_uv,  // bridge supply undervoltage
    input  wire logic                logic_regulator_uv, // logic regulator uv
    input  wire logic                gate_regulator_uv,  // gate regulator uv
    input  wire logic [SWITCHES-1:0] bootstrap_uv,   // per-switch bootstrap uv
    input  wire logic                temp_warn,      // temperature warning
    input  wire logic                over_temp,      // overtemperature
    input  wire logic [SWITCHES-1:0] drain_source_voltage_ov, // per-switch overvoltage
    input  wire logic                sync_lost,      // loss of synchronisation
    input  wire logic                over_speed,     // speed above max level
    input  wire logic                speed_tach_signal, // tach square wave
    input  wire logic                motor_stopped,  // motor stationary
    input  wire logic                serial_strobe_n, // serial strobe, active low
    input  wire logic                serial_clk,     // serial shift clock
    input  wire logic                serial_word_sel, // 0 status, 1 detail
    input  wire logic                link_transmit_input, // pwm demand input
    output logic                     serial_data_out, // serial output
    output logic                     fault_report_pin_o,    // pin drive value
    output logic                     fault_report_pin_oe_n, // low while pulling
    output logic                     gate_drive_off, // all gate drives low
    output logic                     demand_level,   // held demand input level
    output logic                     common_fault_flag // status bit 15
);
    localparam int TW = $clog2(25 * TICK_CYC + 1);
    localparam logic [TW-1:0] T_TICK = TW'(TICK_CYC);
    localparam logic [TW-1:0] C_UV = TW'(`FDR_T_UV_MS / `FDR_TICK_MS * TICK_CYC);
    localparam logic [TW-1:0] C_OT = TW'(`FDR_T_OT_MS / `FDR_TICK_MS * TICK_CYC);
    localparam logic [TW-1:0] C_SD = TW'(`FDR_T_SD_MS / `FDR_TICK_MS * TICK_CYC);
    localparam logic [TW-1:0] C_LK = TW'(`FDR_T_LK_MS / `FDR_TICK_MS * TICK_CYC);
    localparam logic [TW-1:0] C_HI = TW'(`FDR_T_HIGH_MS / `FDR_TICK_MS * TICK_CYC);

    if (SWITCHES != 6 || TICK_CYC < 1 || DIV_W < 1 || DIV_W > 8) begin : g_bad_params
        $error("fdr_top: unsupported parameters");
    end

    typedef struct packed {
        logic [31:0]         prdata;
        logic                pready;
        logic                pslverr;
        logic [1:0]          sel;
        logic                inhibit;
        logic                ck_en;
        logic [DIV_W-1:0]    div;
        logic [6:0]          mask;
        logic [15:0]         st_lat;
        logic [12:0]         dt_lat;
        logic [15:0]         shift;
        logic [15:0]         snap;
        logic                snap_dt;
        logic [4:0]          nbits;
        logic                sclk_q;
        logic                stb_q;
        logic [DIV_W-1:0]    div_cnt;
        logic                ck_q;
        logic                sdo;
        fdr_pulse_t          pst;
        fdr_group_t          grp;
        logic [TW-1:0]       tcnt;
        logic                pin_oe_n;
        logic                pin_o;
        logic                gate_off;
        logic                demand;
        logic                ff;
    } fdr_state_t;

    fdr_state_t s_r;
    fdr_state_t s_nxt;

    logic [15:0]         st_set;
    logic [12:0]         dt_set;
    logic [15:0]         st_word;
    logic [15:0]         dt_word;
    logic                ff_now;
    fdr_group_t          grp_now;
    logic [TW-1:0]       low_len;
    logic                want_low;
    logic                apb_acc;
    logic                mapped;
    logic [31:0]         rd_word;

    always_comb begin
        st_set = 16'h0000;
        st_set[`FDR_ST_SYS]   = sys_err;
        st_set[`FDR_ST_SER]   = serial_err;
        st_set[`FDR_ST_BBPOR] = bridge_supply_por;
        st_set[`FDR_ST_BBUV]  = bridge_supply_uv & ~s_r.mask[`FDR_MSK_BBUV];
        st_set[`FDR_ST_LRUV]  = logic_regulator_uv;
        st_set[`FDR_ST_GRUV]  = gate_regulator_uv;
        st_set[`FDR_ST_BSUV]  = |bootstrap_uv & ~s_r.mask[`FDR_MSK_BSUV];
        st_set[`FDR_ST_TW]    = temp_warn & ~s_r.mask[`FDR_MSK_TW];
        st_set[`FDR_ST_OT]    = over_temp & ~s_r.mask[`FDR_MSK_OT];
        st_set[`FDR_ST_DSOV]  = |drain_source_voltage_ov & ~s_r.mask[`FDR_MSK_DSOV];
        st_set[`FDR_ST_LOCK]  = sync_lost & ~s_r.mask[`FDR_MSK_LOCK];
        st_set[`FDR_ST_OSPD]  = over_speed & ~s_r.mask[`FDR_MSK_OSPD];
        dt_set[`FDR_DT_DSOV_LO +: 6] = s_r.mask[`FDR_MSK_DSOV] ? 6'h00
                                                               : drain_source_voltage_ov;
        dt_set[`FDR_DT_BSUV_LO +: 6] = s_r.mask[`FDR_MSK_BSUV] ? 6'h00 : bootstrap_uv;
        dt_set[`FDR_DT_OSPD]         = st_set[`FDR_ST_OSPD];

        ff_now  = (|s_r.st_lat[14:0]) | (|s_r.dt_lat);
        st_word = {ff_now, s_r.st_lat[14:0]};
        dt_word = {3'h0, s_r.dt_lat};

        grp_now = FDR_G_NONE;
        if (st_set[`FDR_ST_LOCK] | s_r.st_lat[`FDR_ST_LOCK])
            grp_now = FDR_G_LOCK;
        if (st_set[`FDR_ST_DSOV] | s_r.st_lat[`FDR_ST_DSOV])
            grp_now = FDR_G_SD;
        if (st_set[`FDR_ST_OT] | s_r.st_lat[`FDR_ST_OT])
            grp_now = FDR_G_OT;
        if (|(st_set[`FDR_ST_BBUV:`FDR_ST_BSUV] | s_r.st_lat[`FDR_ST_BBUV:`FDR_ST_BSUV]))
            grp_now = FDR_G_UV;
        if (st_set[`FDR_ST_SYS] | s_r.st_lat[`FDR_ST_SYS])
            grp_now = FDR_G_SYS;

        unique case (grp_now)
            FDR_G_UV:   low_len = C_UV;
            FDR_G_OT:   low_len = C_OT;
            FDR_G_SD:   low_len = C_SD;
            FDR_G_LOCK: low_len = C_LK;
            default:    low_len = T_TICK;
        endcase

        apb_acc = psel & penable & s_r.pready;
        mapped  = 1'b1;
        rd_word = 32'h0000_0000;
        unique case (paddr)
            `FDR_OFS_CTRL: begin
                rd_word[`FDR_CTRL_SEL_LO +: 2]     = s_r.sel;
                rd_word[`FDR_CTRL_INH]             = s_r.inhibit;
                rd_word[`FDR_CTRL_CKEN]            = s_r.ck_en;
                rd_word[`FDR_CTRL_DIV_LO +: DIV_W] = s_r.div;
            end
            `FDR_OFS_MASK:   rd_word[6:0]  = s_r.mask;
            `FDR_OFS_STATUS: rd_word[15:0] = st_word;
            `FDR_OFS_DETAIL: rd_word[15:0] = dt_word;
            `FDR_OFS_REPORT: rd_word[7:0]  = {s_r.gate_off, ~s_r.pin_oe_n, s_r.pst, 1'b0,
                                              s_r.grp};
            default:         mapped  = 1'b0;
        endcase

        s_nxt = s_r;

        // apb slave: no wait state, answer from data registered in the setup cycle
        s_nxt.pready  = psel & ~penable & ~s_r.pready;
        s_nxt.pslverr = psel & ~penable & ~s_r.pready & ~mapped;
        if (psel & ~penable & ~s_r.pready)
            s_nxt.prdata = pwrite ? 32'h0000_0000 : rd_word;
        if (apb_acc & pwrite & (paddr == `FDR_OFS_CTRL)) begin
            s_nxt.sel     = pwdata[`FDR_CTRL_SEL_LO +: 2];
            s_nxt.inhibit = pwdata[`FDR_CTRL_INH];
            s_nxt.ck_en   = pwdata[`FDR_CTRL_CKEN];
            s_nxt.div     = pwdata[`FDR_CTRL_DIV_LO +: DIV_W];
        end
        if (apb_acc & pwrite & (paddr == `FDR_OFS_MASK))
            s_nxt.mask = pwdata[6:0];

        // serial readback
        s_nxt.stb_q  = serial_strobe_n;
        s_nxt.sclk_q = serial_clk;
        if (serial_strobe_n) begin
            s_nxt.shift   = serial_word_sel ? dt_word : st_word;
            s_nxt.snap    = serial_word_sel ? dt_word : st_word;
            s_nxt.snap_dt = serial_word_sel;
            s_nxt.nbits   = 5'h00;
        end else if (serial_clk & ~s_r.sclk_q) begin
            s_nxt.shift = {s_r.shift[14:0], 1'b0};
            if (s_r.nbits != 5'(`FDR_WORD_BITS))
                s_nxt.nbits = s_r.nbits + 5'h01;
        end

        // read bits clear at strobe release; a new event still sets
        if (serial_strobe_n & ~s_r.stb_q & ~s_r.inhibit &
            (s_r.nbits == 5'(`FDR_WORD_BITS))) begin
            if (s_r.snap_dt)
                s_nxt.dt_lat = s_r.dt_lat & ~s_r.snap[12:0];
            else
                s_nxt.st_lat = s_r.st_lat & ~{1'b0, s_r.snap[14:0]};
        end
        if (bridge_supply_por) begin
            s_nxt.st_lat = 16'h0000;
            s_nxt.dt_lat = 13'h0000;
        end
        s_nxt.st_lat = s_nxt.st_lat | {1'b0, st_set[14:0]};
        s_nxt.dt_lat = s_nxt.dt_lat | dt_set;
        s_nxt.ff     = (|s_nxt.st_lat) | (|s_nxt.dt_lat);

        if (s_r.div_cnt >= s_r.div) begin
            s_nxt.div_cnt = '0;
            s_nxt.ck_q    = ~s_r.ck_q;
        end else begin
            s_nxt.div_cnt = s_r.div_cnt + DIV_W'(1);
        end
        if (s_r.ck_en)
            s_nxt.sdo = s_nxt.ck_q;
        else if (serial_strobe_n)
            s_nxt.sdo = st_word[`FDR_ST_FF] | serial_word_sel & dt_word[15];
        else
            s_nxt.sdo = s_nxt.shift[15];

        // pulse sequencer; idle closes each high phase
        s_nxt.tcnt = (s_r.tcnt != '0) ? s_r.tcnt - TW'(1) : '0;
        unique case (s_r.pst)
            FDR_IDLE: begin
                if (grp_now != FDR_G_NONE && grp_now != FDR_G_SYS) begin
                    s_nxt.pst  = FDR_LOW;
                    s_nxt.grp  = grp_now;
                    s_nxt.tcnt = low_len - TW'(1);
                end
            end
            FDR_LOW: begin
                if (s_r.tcnt == '0) begin
                    s_nxt.pst  = FDR_HIGH;
                    s_nxt.tcnt = C_HI - TW'(2);
                end
            end
            FDR_HIGH: begin
                if (s_r.tcnt == '0)
                    s_nxt.pst = FDR_IDLE;
            end
            default: s_nxt.pst = FDR_IDLE;
        endcase
        if (grp_now == FDR_G_SYS || grp_now == FDR_G_NONE || s_r.sel[1] == 1'b0) begin
            s_nxt.pst  = FDR_IDLE;
            s_nxt.grp  = grp_now;
            s_nxt.tcnt = '0;
        end

        unique case (s_r.sel)
            2'd0: want_low = grp_now != FDR_G_NONE;
            2'd1: want_low = ~speed_tach_signal & ~motor_stopped;
            2'd2: want_low = grp_now == FDR_G_SYS || s_nxt.pst == FDR_LOW;
            default: begin
                if (grp_now == FDR_G_NONE)
                    want_low = ~speed_tach_signal & ~motor_stopped;
                else
                    want_low = grp_now == FDR_G_SYS || s_nxt.pst == FDR_LOW;
            end
        endcase
        s_nxt.pin_oe_n = ~want_low;
        s_nxt.pin_o   = 1'b0;

        // in select 2, demand input is frozen while our own pin pulls the shared line low
        if (!(s_r.sel == 2'd2 && !s_r.pin_oe_n))
            s_nxt.demand = link_transmit_input;

        s_nxt.gate_off = bridge_supply_por | gate_regulator_uv;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r          <= '0;
            s_r.sel      <= 2'(`FDR_CTRL_RST);
            s_r.pin_oe_n <= 1'b1;
            s_r.mask     <= `FDR_MASK_RST;
            s_r.stb_q    <= 1'b1;
            s_r.pst      <= FDR_IDLE;
            s_r.grp      <= FDR_G_NONE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata                = s_r.prdata;
    assign pready                = s_r.pready;
    assign pslverr               = s_r.pslverr;
    assign serial_data_out       = s_r.sdo;
    assign fault_report_pin_o    = s_r.pin_o;
    assign fault_report_pin_oe_n = s_r.pin_oe_n;
    assign gate_drive_off        = s_r.gate_off;
    assign demand_level          = s_r.demand;
    assign common_fault_flag     = s_r.ff;
endmodule

// >>> fdr_top_properties.sv
// assertions on the fault reporter ports
// assumes binding into fdr_top; report select shadowed from apb writes
`timescale 1ns/1ps
`include "fdr_cfg.svh"
module fdr_top_properties (
    input wire logic        pclk,                  // clock
    input wire logic        presetn,               // reset
    input wire logic        psel,                  // select
    input wire logic        penable,               // enable
    input wire logic        pwrite,                // direction
    input wire logic [7:0]  paddr,                 // address
    input wire logic [31:0] pwdata,                // write data
    input wire logic        pready,                // ready
    input wire logic        sys_err,               // system
    input wire logic        logic_regulator_uv,    // logic uv
    input wire logic        gate_regulator_uv,     // gate uv
    input wire logic        bridge_supply_por,     // supply reset
    input wire logic        speed_tach_signal,     // tach
    input wire logic        motor_stopped,         // stopped
    input wire logic        serial_strobe_n,       // strobe
    input wire logic        serial_data_out,       // serial out
    input wire logic        fault_report_pin_o,    // pin value
    input wire logic        fault_report_pin_oe_n, // pin enable
    input wire logic        gate_drive_off,        // gates off
    input wire logic        demand_level,          // demand
    input wire logic        common_fault_flag      // flag
);
    logic [1:0] sel_r;
    // select mirrored from completed writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            sel_r <= 2'h0;
        else if (psel && penable && pready && pwrite && paddr == `FDR_OFS_CTRL)
            sel_r <= pwdata[1:0];
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    gate_force_off_a:
        assert property ((bridge_supply_por || gate_regulator_uv) |=> gate_drive_off)
        else $error("gates not off");
    gate_release_a:
        assert property (!(bridge_supply_por || gate_regulator_uv) |=> !gate_drive_off)
        else $error("gates off without cause");
    pin_pull_only_a:
        assert property (!fault_report_pin_o) else $error("pin driven high");
    flag_on_fault_a:
        assert property (sys_err |-> ##[1:3] common_fault_flag) else $error("flag missing");
    strobe_flag_a:
        assert property ($fell(serial_strobe_n) |-> serial_data_out == $past(common_fault_flag))
        else $error("serial out not flag");
    sys_pin_low_a:
        assert property ((sel_r[1] && sys_err) [*2] |=> !fault_report_pin_oe_n)
        else $error("system pin not low");
    sel0_fault_low_a:
        assert property ((sel_r == 2'h0 && (logic_regulator_uv || gate_regulator_uv)) [*2]
            |=> !fault_report_pin_oe_n) else $error("pin not low");
    sel1_tach_a:
        assert property ((sel_r == 2'h1) [*2] |=> fault_report_pin_oe_n
            == ($past(speed_tach_signal) || $past(motor_stopped))) else $error("tach wrong");
    demand_hold_a:
        assert property ((sel_r == 2'h2 && !fault_report_pin_oe_n) [*2] |-> $stable(demand_level))
        else $error("demand moved");
    cover property (sel_r == 2'h2 && !fault_report_pin_oe_n);
    cover property ($fell(serial_strobe_n) && common_fault_flag);
    cover property (gate_drive_off);
endmodule
bind fdr_top fdr_top_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .sys_err, .logic_regulator_uv, .gate_regulator_uv, .bridge_supply_por,
    .speed_tach_signal, .motor_stopped, .serial_strobe_n, .serial_data_out, .fault_report_pin_o,
    .fault_report_pin_oe_n, .gate_drive_off, .demand_level, .common_fault_flag);

// >>> test_fault_diagnostic_reporter.sv
// bench of the fault reporter: registers, serial word, report pin
// assumes fdr_top, host model and bound checker compiled first
`timescale 1ns/1ps
`include "fdr_cfg.svh"
module test_fault_diagnostic_reporter;
    localparam int TICK = 10;
    logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic        pready, pslverr, perr, sys_err, serial_err, bridge_supply_por, pin_lvl;
    logic        bridge_supply_uv, logic_regulator_uv, gate_regulator_uv, temp_warn, over_temp;
    logic        sync_lost, over_speed, speed_tach_signal, motor_stopped, link_transmit_input;
    logic [5:0]  bootstrap_uv, drain_source_voltage_ov, dsv, bsv;
    logic        serial_strobe_n, serial_clk, serial_word_sel, serial_data_out, demand_level;
    logic        fault_report_pin_o, fault_report_pin_oe_n, gate_drive_off, common_fault_flag;
    logic [15:0] w;
    int          fails = 0, comparisons = 0, cyc = 0, lo, hi, n;
    fdr_top #(.TICK_CYC(TICK)) u_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .sys_err, .serial_err, .bridge_supply_por, .bridge_supply_uv, .logic_regulator_uv,
        .gate_regulator_uv, .bootstrap_uv, .temp_warn, .over_temp, .drain_source_voltage_ov,
        .sync_lost, .over_speed, .speed_tach_signal, .motor_stopped, .serial_strobe_n,
        .serial_clk, .serial_word_sel, .link_transmit_input, .serial_data_out,
        .fault_report_pin_o, .fault_report_pin_oe_n, .gate_drive_off, .demand_level,
        .common_fault_flag);
    fdr_host_model u_host (.pclk, .pin_o(fault_report_pin_o), .pin_oe_n(fault_report_pin_oe_n),
        .sdo(serial_data_out), .strobe_n(serial_strobe_n), .sclk(serial_clk),
        .word_sel(serial_word_sel), .pin_lvl);
    always #50 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        link_transmit_input <= 1'($urandom);
        if (cyc % 8 == 0)
            speed_tach_signal <= 1'($urandom);
        if (cyc == 40000) begin
            fails++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        perr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    task automatic clear_all();
        {sys_err, bridge_supply_uv, logic_regulator_uv, gate_regulator_uv, over_temp, sync_lost,
            over_speed, bootstrap_uv, drain_source_voltage_ov, bridge_supply_por} <= 20'h1;
        repeat (3) @(posedge pclk);
        bridge_supply_por <= 1'h0;
        repeat (3) @(posedge pclk);
    endtask
    function automatic int exp_low(input int g);
        int ms[4] = '{`FDR_T_LK_MS, `FDR_T_SD_MS, `FDR_T_OT_MS, `FDR_T_UV_MS};
        return ms[g] / `FDR_TICK_MS * TICK;
    endfunction
    initial begin
        {sys_err, serial_err, bridge_supply_por, bridge_supply_uv, logic_regulator_uv,
            gate_regulator_uv, temp_warn, over_temp, sync_lost, over_speed, motor_stopped,
            bootstrap_uv, drain_source_voltage_ov} = '0;
        void'($urandom(47781));
        repeat (12) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        apb(1'h0, `FDR_OFS_CTRL, 32'h0, r);
        chk(r, `FDR_CTRL_RST);
        apb(1'h0, 8'h14, 32'h0, r);
        chk(perr, 1'h1);
        // inhibit lets one word be read twice
        apb(1'h1, `FDR_OFS_CTRL, 32'h1 << `FDR_CTRL_INH, r);
        {logic_regulator_uv, gate_regulator_uv} <= 2'h3;
        repeat (2 + $urandom % 6) @(posedge pclk);
        chk(gate_drive_off, 1'h1);
        {logic_regulator_uv, gate_regulator_uv} <= 2'h0;
        repeat (3) @(posedge pclk);
        chk(pin_lvl, 1'h0);
        for (int i = 0; i < 3; i++) begin
            if (i == 2)
                apb(1'h1, `FDR_OFS_CTRL, 32'h0, r);
            u_host.read_word(1'h0, w);
            chk(w[15], 1'h1);
            chk({w[`FDR_ST_LRUV], w[`FDR_ST_GRUV]}, 32'h3);
        end
        apb(1'h0, `FDR_OFS_STATUS, 32'h0, r);
        chk(r, 32'h0);
        chk(pin_lvl, 1'h1);
        dsv = 6'(1 + $urandom % 63);
        bsv = 6'($urandom);
        {drain_source_voltage_ov, bootstrap_uv, over_speed} <= {dsv, bsv, 1'h1};
        repeat (3) @(posedge pclk);
        apb(1'h0, `FDR_OFS_DETAIL, 32'h0, r);
        chk(r[12:0], {1'h1, bsv, dsv});
        clear_all();
        apb(1'h1, `FDR_OFS_MASK, 32'h1 << `FDR_MSK_DSOV, r);
        drain_source_voltage_ov <= dsv;
        repeat (3) @(posedge pclk);
        apb(1'h0, `FDR_OFS_STATUS, 32'h0, r);
        chk(r[`FDR_ST_DSOV], 1'h0);
        apb(1'h1, `FDR_OFS_MASK, 32'h0, r);
        clear_all();
        // lower groups stay raised; top one must win
        for (int g = 0; g < 4; g++) begin
            apb(1'h1, `FDR_OFS_CTRL, 32'h2, r);
            chk(pin_lvl, 1'h1);
            sync_lost <= 1'h1;
            drain_source_voltage_ov <= {5'h0, 1'(g >= 1)};
            over_temp <= 1'(g >= 2);
            bridge_supply_uv <= 1'(g >= 3);
            u_host.pulse_times(lo, hi);
            chk(lo, exp_low(g));
            chk(hi, `FDR_T_HIGH_MS / `FDR_TICK_MS * TICK);
            clear_all();
        end
        apb(1'h1, `FDR_OFS_CTRL, 32'h3, r);
        sys_err <= 1'h1;
        repeat (400) @(posedge pclk);
        chk(pin_lvl, 1'h0);
        clear_all();
        for (int s = 1; s < 4; s += 2) begin
            apb(1'h1, `FDR_OFS_CTRL, 32'(s), r);
            for (int k = 0; k < 6; k++) begin
                motor_stopped <= 1'($urandom);
                repeat (2) @(posedge pclk);
                while (cyc % 8 != 4) @(posedge pclk);
                chk(pin_lvl, speed_tach_signal | motor_stopped);
            end
        end
        apb(1'h1, `FDR_OFS_CTRL, (32'h3 << `FDR_CTRL_DIV_LO) | (32'h1 << `FDR_CTRL_CKEN), r);
        @(posedge pclk);
        w[0] = serial_data_out;
        for (n = 0; n < 50 && serial_data_out === w[0]; n++) @(posedge pclk);
        for (n = 0; n < 50 && serial_data_out !== w[0]; n++) @(posedge pclk);
        chk(n, 32'h4);
        complete_run();
    end
endmodule
